// ### design/fos_params.svh
/*
 * Command codes, status bit positions and the status reset value for the flash
 * output-select control block.
 * Assumes it is included by bare name from design files that need it.
 */
`ifndef FOS_PARAMS_SVH
`define FOS_PARAMS_SVH

// ****************************************
// command codes (low byte of a bus write); the block word is the full 16 bits
// ****************************************
`define FOS_C_READ_ARRAY  8'hff
`define FOS_C_PGM_A       8'h10
`define FOS_C_PGM_B       8'h40
`define FOS_C_BUF_PGM     8'he8
`define FOS_C_ERASE       8'h20
`define FOS_C_BULK        8'h30
`define FOS_C_CONFIRM     8'hd0
`define FOS_C_SUSPEND     8'hb0
`define FOS_C_READ_STATUS 8'h70
`define FOS_C_CLR_STATUS  8'h50
`define FOS_C_READ_ID     8'h90
`define FOS_C_READ_QUERY  8'h98
`define FOS_C_LOCK_SETUP  8'h60
`define FOS_C_OTP         8'hc0
`define FOS_C_LOCK        8'h01
`define FOS_C_LOCKDOWN    8'h2f
`define FOS_C_CFG         8'h03
`define FOS_BLOCK_WORD    16'hffff

// ****************************************
// status word layout and reset value
// ****************************************
`define FOS_SB_READY 7
`define FOS_SB_ESUSP 6
`define FOS_SB_VPP   3
`define FOS_SB_PSUSP 2
`define FOS_SB_LOCK  1
`define FOS_SB_BULK  0
`define FOS_STATUS_RST 8'h80

// first word offset of the query table; identifier data lies below it
`define FOS_QUERY_BASE 8'h10

`endif

// ### design/fos_pkg.sv
/*
 * Types shared by the output-select control block: chip states,
 * output selections and the operations handed to the write sequencer.
 * Assumes nothing of its surroundings.
 */
package fos_pkg;

	// ****************************************
	// chip state
	// ****************************************
	typedef enum logic [3:0] {
		st_ready      = 4'b0000,
		st_pgm_setup  = 4'b0001,
		st_pgm_busy   = 4'b0010,
		st_pgm_susp   = 4'b0011,
		st_erase_setup = 4'b0100,
		st_erase_busy = 4'b0101,
		st_erase_susp = 4'b0110,
		st_bp_setup   = 4'b0111,
		st_bp_busy    = 4'b1000,
		st_bulk_setup = 4'b1001,
		st_bulk_busy  = 4'b1010,
		st_otp_setup  = 4'b1011,
		st_otp_busy   = 4'b1100,
		st_lock_setup = 4'b1101
	} fos_state_t;

	// ****************************************
	// output selection of a partition
	// ****************************************
	typedef enum logic [1:0] {
		sel_array  = 2'b00,
		sel_id     = 2'b01,
		sel_status = 2'b10
	} fos_sel_t;

	// ****************************************
	// operation started on the write sequencer
	// ****************************************
	typedef enum logic [3:0] {
		op_word_pgm = 4'b0000,
		op_buf_pgm  = 4'b0001,
		op_erase    = 4'b0010,
		op_bulk     = 4'b0011,
		op_otp      = 4'b0100,
		op_lock     = 4'b0101,
		op_unlock   = 4'b0110,
		op_lockdown = 4'b0111,
		op_cfg      = 4'b1000
	} fos_op_t;

endpackage

// ### design/fos_sel_mem.sv
/*
 * Per-partition output-selection memory: one two-bit flip-flop entry
 * per partition, written by index, all entries visible at once.
 * Assumes a single clock and synchronous active-low reset.
 */
`timescale 1ns/1ps
module fos_sel_mem #(
	parameter int NPART = 8,
	parameter int PW    = 3
) (
	input  logic                 mclk,
	input  logic                 resetn,
	input  logic                 wr_en,
	input  logic [PW-1:0]        wr_idx,
	input  fos_pkg::fos_sel_t    wr_sel,
	output logic [2*NPART-1:0]   all_sel
);
	import fos_pkg::*;

	// ****************************************
	// storage
	// ****************************************
	logic [1:0] mem [NPART];

	// only the written partition moves; others keep their last pointer
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			for (int i = 0; i < NPART; i++) begin
				mem[i] <= sel_array;
			end
		end else if (wr_en) begin
			mem[wr_idx] <= wr_sel;
		end
	end

	// flatten for the reader
	always_comb begin
		for (int i = 0; i < NPART; i++) begin
			all_sel[2*i +: 2] = mem[i];
		end
	end

endmodule

// ### design/fos_output_select.sv
/*
 * Command interpreter of a partitioned NOR flash: tracks the chip state,
 * steers each partition's read-output selection, keeps the status word
 * and starts operations on the write sequencer.
 * Assumes bus writes arrive as one-cycle pulses on mclk and that the
 * write sequencer reports completion and errors as one-cycle pulses.
 */
// Behaviour
// - any write in a setup, load or confirm state selects status output, except 03 in lock setup, which selects array
// - ready-like states: FF array, 90/98 identifier, 60 status, 50 no change
// - ready-like states: C0 status; 01/2F/03 and illegal keep; block word array
// - write sequencer completion leaves every output selection unchanged
// - codes outside the accepted set are illegal commands
// - array read of busy partition is invalid; identifier and query apart
// - erase setup then confirm while program-suspended: confirm dropped
// - clear-status clears error bits only while sequencer is idle
// - bulk programming takes data only while status bit 0 is 0
// - each partition keeps its own selection from the last command
// - next chip state depends on chip state, bus and sequencer inputs, never on selections
// - lock, unlock, lock-down, configuration confirm run then go ready, or back to erase suspend if entered from it
// - block address of first cycle latched, used on later cycles
// - status bit 7 ready, bit 3 voltage error, bit 1 locked block
`timescale 1ns/1ps
`include "fos_params.svh"
module fos_output_select #(
	parameter int NPART = 8,
	parameter int PW    = 3,
	parameter int BW    = 10
) (
	input  logic                 mclk,
	input  logic                 resetn,
	input  logic                 wr_valid,
	input  logic [15:0]          wr_data,
	input  logic [PW-1:0]        wr_partition,
	input  logic [BW-1:0]        wr_block,
	input  logic [PW-1:0]        rd_partition,
	input  logic [7:0]           rd_offset,
	input  logic                 seq_done,
	input  logic                 seq_vpp_err,
	input  logic                 seq_lock_err,
	input  logic                 bulk_not_ready,
	output fos_pkg::fos_state_t  chip_state,
	output fos_pkg::fos_sel_t    rd_sel,
	output logic                 rd_invalid,
	output logic                 rd_query,
	output logic [2*NPART-1:0]   part_sel,
	output logic [7:0]           status_word,
	output logic                 op_start,
	output fos_pkg::fos_op_t     op_kind,
	output logic [BW-1:0]        op_block,
	output logic [PW-1:0]        op_partition,
	output logic                 bulk_data_accept,
	output logic                 cmd_ignored,
	output logic                 cmd_illegal
);
	import fos_pkg::*;

	// ****************************************
	// decode helpers
	// ****************************************
	function automatic logic is_setup(input fos_state_t s);
		return s inside {st_pgm_setup, st_erase_setup, st_bp_setup,
			st_bulk_setup, st_bulk_busy, st_otp_setup};
	endfunction

	function automatic logic is_busy(input fos_state_t s);
		return s inside {st_pgm_busy, st_erase_busy, st_bp_busy,
			st_otp_busy, st_bulk_busy};
	endfunction

	// states that read the bus as a command rather than as data
	function automatic logic takes_cmd(input fos_state_t s);
		return !is_setup(s) && s != st_lock_setup && s != st_otp_busy;
	endfunction

	function automatic logic is_legal(input logic [7:0] c);
		return c inside {`FOS_C_READ_ARRAY, `FOS_C_PGM_A, `FOS_C_PGM_B,
			`FOS_C_BUF_PGM, `FOS_C_ERASE, `FOS_C_BULK, `FOS_C_CONFIRM,
			`FOS_C_SUSPEND, `FOS_C_READ_STATUS, `FOS_C_CLR_STATUS,
			`FOS_C_READ_ID, `FOS_C_READ_QUERY, `FOS_C_LOCK_SETUP,
			`FOS_C_OTP, `FOS_C_LOCK, `FOS_C_LOCKDOWN, `FOS_C_CFG};
	endfunction

	function automatic fos_sel_t sel_of(input logic [2*NPART-1:0] v,
			input logic [PW-1:0] idx);
		return fos_sel_t'(v[2*idx +: 2]);
	endfunction

	// ****************************************
	// state
	// ****************************************
	fos_state_t state;
	fos_state_t resume;
	logic       esusp;
	logic       pend_ignore;
	logic       vpp_err;
	logic       lock_err;

	fos_state_t next_state;
	fos_state_t next_resume;
	logic       next_esusp;
	logic       next_pend;
	logic       start;
	fos_op_t    kind;
	logic       latch;
	logic       accept;
	logic       ignore;

	// ****************************************
	// decode of the current write
	// ****************************************
	wire logic [7:0] code      = wr_data[7:0];
	wire logic       blk_word  = (wr_data == `FOS_BLOCK_WORD);
	wire logic       cmd_write = wr_valid && takes_cmd(state);
	wire logic       same_blk  = (wr_block == op_block);
	wire fos_sel_t   cur_sel   = sel_of(part_sel, wr_partition);
	wire logic       illegal   = cmd_write && !blk_word && !is_legal(code);
	wire logic       clr_req   = cmd_write && code == `FOS_C_CLR_STATUS;
	// blocked while the sequencer runs, including all bulk states
	wire logic       clr_ok    = clr_req && !is_busy(state);

	// ****************************************
	// output selection of the written partition
	// ****************************************
	fos_sel_t next_sel;
	always_comb begin
		next_sel = cur_sel;
		if (is_setup(state)) begin
			next_sel = sel_status;
		end else if (state == st_lock_setup) begin
			next_sel = (code == `FOS_C_CFG) ? sel_array : sel_status;
		end else if (state == st_otp_busy) begin
			next_sel = sel_status;
		end else if (blk_word) begin
			next_sel = sel_array;
		end else begin
			case (code)
				`FOS_C_READ_ARRAY: next_sel = sel_array;
				`FOS_C_READ_ID,
				`FOS_C_READ_QUERY: next_sel = sel_id;
				`FOS_C_PGM_A, `FOS_C_PGM_B, `FOS_C_BUF_PGM, `FOS_C_ERASE,
				`FOS_C_BULK, `FOS_C_CONFIRM, `FOS_C_SUSPEND,
				`FOS_C_READ_STATUS, `FOS_C_LOCK_SETUP,
				`FOS_C_OTP: next_sel = sel_status;
				// 50, 01, 2F, 03 and illegal codes keep the pointer
				default: next_sel = cur_sel;
			endcase
		end
	end

	// completion alone never writes the memory
	fos_sel_mem #(.NPART(NPART), .PW(PW)) u_sel (
		.mclk    (mclk),
		.resetn  (resetn),
		.wr_en   (wr_valid),
		.wr_idx  (wr_partition),
		.wr_sel  (next_sel),
		.all_sel (part_sel)
	);

	// ****************************************
	// chip next state: reads state, bus and sequencer inputs, never part_sel
	// ****************************************
	always_comb begin
		next_state  = state;
		next_resume = resume;
		next_esusp  = esusp;
		next_pend   = pend_ignore;
		start       = 1'b0;
		kind        = op_word_pgm;
		latch       = 1'b0;
		accept      = 1'b0;
		ignore      = 1'b0;
		// completion wins over a racing write to a busy state
		if (seq_done && is_busy(state)) begin
			next_state = (esusp && state != st_erase_busy) ? st_erase_susp : st_ready;
			next_esusp = 1'b0;
		end else if (wr_valid) begin
			case (state)
				st_ready, st_erase_susp: begin
					latch = 1'b1;
					case (code)
						`FOS_C_PGM_A, `FOS_C_PGM_B: next_state = st_pgm_setup;
						`FOS_C_BUF_PGM: next_state = st_bp_setup;
						`FOS_C_LOCK_SETUP: next_state = st_lock_setup;
						`FOS_C_ERASE: if (state == st_ready) next_state = st_erase_setup;
						`FOS_C_BULK: if (state == st_ready) next_state = st_bulk_setup;
						`FOS_C_OTP: if (state == st_ready) next_state = st_otp_setup;
						`FOS_C_CONFIRM: begin
							if (state == st_erase_susp) next_state = st_erase_busy;
						end
						default: latch = 1'b0;
					endcase
					next_esusp = (state == st_erase_susp) && next_state != st_erase_busy;
				end
				st_pgm_setup: begin
					start      = 1'b1;
					next_state = st_pgm_busy;
				end
				st_erase_setup: begin
					start      = (code == `FOS_C_CONFIRM);
					kind       = op_erase;
					next_state = start ? st_erase_busy : st_ready;
				end
				st_bp_setup: begin
					start      = (code == `FOS_C_CONFIRM);
					kind       = op_buf_pgm;
					next_state = start ? st_bp_busy : st_bp_setup;
				end
				// second cycle must hit the first cycle's block, else back to ready without a start
				st_bulk_setup: begin
					start      = same_blk;
					kind       = op_bulk;
					next_state = start ? st_bulk_busy : st_ready;
				end
				st_bulk_busy: begin
					if (!same_blk) begin
						next_state = st_ready;
					end else begin
						accept = !bulk_not_ready;
						ignore = bulk_not_ready;
					end
				end
				st_otp_setup: begin
					start      = 1'b1;
					kind       = op_otp;
					next_state = st_otp_busy;
				end
				st_lock_setup: begin
					start = 1'b1;
					case (code)
						`FOS_C_LOCK:     kind = op_lock;
						`FOS_C_CONFIRM:  kind = op_unlock;
						`FOS_C_LOCKDOWN: kind = op_lockdown;
						`FOS_C_CFG:      kind = op_cfg;
						default:         start = 1'b0;
					endcase
					next_state = esusp ? st_erase_susp : st_ready;
					next_esusp = 1'b0;
				end
				st_pgm_busy, st_bp_busy: begin
					if (code == `FOS_C_SUSPEND) begin
						next_resume = state;
						next_state  = st_pgm_susp;
					end
				end
				st_erase_busy: begin
					if (code == `FOS_C_SUSPEND) next_state = st_erase_susp;
				end
				st_pgm_susp: begin
					next_pend = (code == `FOS_C_ERASE);
					// ambiguous erase-or-resume: drop the confirm
					if (pend_ignore && code == `FOS_C_CONFIRM) begin
						ignore = 1'b1;
					end else if (code == `FOS_C_CONFIRM) begin
						next_state = resume;
					end
				end
				default: next_state = state;
			endcase
		end
	end

	// ****************************************
	// registers
	// ****************************************
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			state       <= st_ready;
			resume      <= st_pgm_busy;
			esusp       <= 1'b0;
			pend_ignore <= 1'b0;
		end else begin
			state       <= next_state;
			resume      <= next_resume;
			esusp       <= next_esusp;
			pend_ignore <= next_pend;
		end
	end

	// pulses and latched operation target
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			op_start         <= 1'b0;
			op_kind          <= op_word_pgm;
			op_block         <= '0;
			op_partition     <= '0;
			bulk_data_accept <= 1'b0;
			cmd_ignored      <= 1'b0;
			cmd_illegal      <= 1'b0;
		end else begin
			op_start         <= start;
			op_kind          <= start ? kind : op_kind;
			bulk_data_accept <= accept;
			cmd_ignored      <= ignore;
			cmd_illegal      <= illegal;
			if (latch) begin
				op_block     <= wr_block;
				op_partition <= wr_partition;
			end
		end
	end

	// sticky errors: a setting pulse beats a same-cycle clear
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			vpp_err  <= 1'b0;
			lock_err <= 1'b0;
		end else begin
			vpp_err  <= seq_vpp_err || (vpp_err && !clr_ok);
			lock_err <= seq_lock_err || (lock_err && !clr_ok);
		end
	end

	// ****************************************
	// status word and read side
	// ****************************************
	always_comb begin
		status_word                = `FOS_STATUS_RST & 8'h00;
		status_word[`FOS_SB_READY] = !is_busy(state);
		status_word[`FOS_SB_ESUSP] = (state == st_erase_susp) || esusp;
		status_word[`FOS_SB_VPP]   = vpp_err;
		status_word[`FOS_SB_PSUSP] = (state == st_pgm_susp);
		status_word[`FOS_SB_LOCK]  = lock_err;
		status_word[`FOS_SB_BULK]  = bulk_not_ready && state inside {st_bulk_setup, st_bulk_busy};
	end

	assign chip_state = state;
	assign rd_sel     = sel_of(part_sel, rd_partition);
	// busy partition's array holds no valid data
	assign rd_invalid = rd_sel == sel_array && is_busy(state)
		&& rd_partition == op_partition;
	// query table above identifier words, never overlapping
	assign rd_query   = rd_sel == sel_id && rd_offset >= `FOS_QUERY_BASE;

	// ****************************************
	// checks
	// ****************************************
	property p_setup_status;
		@(posedge mclk) disable iff (!resetn)
		wr_valid && is_setup(chip_state) |=>
			sel_of(part_sel, $past(wr_partition)) == sel_status;
	endproperty
	a_setup_status: assert property (p_setup_status)
		else $error("setup write did not select status");

	property p_id_select;
		@(posedge mclk) disable iff (!resetn)
		cmd_write && code == `FOS_C_READ_QUERY |=>
			sel_of(part_sel, $past(wr_partition)) == sel_id;
	endproperty
	a_id_select: assert property (p_id_select)
		else $error("query code did not select identifier output");

	property p_keep_codes;
		@(posedge mclk) disable iff (!resetn)
		cmd_write && (code == `FOS_C_CLR_STATUS || code == `FOS_C_LOCKDOWN) |=>
			$stable(part_sel);
	endproperty
	a_keep_codes: assert property (p_keep_codes)
		else $error("keep code changed a selection");

	property p_done_keep;
		@(posedge mclk) disable iff (!resetn)
		seq_done && !wr_valid |=> $stable(part_sel);
	endproperty
	a_done_keep: assert property (p_done_keep)
		else $error("completion moved a selection");

	property p_illegal;
		@(posedge mclk) disable iff (!resetn)
		cmd_write && !blk_word && !is_legal(code) |=> cmd_illegal && $stable(part_sel);
	endproperty
	a_illegal: assert property (p_illegal)
		else $error("illegal code not flagged or selection moved");

	property p_ignore;
		@(posedge mclk) disable iff (!resetn)
		(chip_state == st_pgm_susp && wr_valid && code == `FOS_C_ERASE && !seq_done)
			##1 !wr_valid ##1 (wr_valid && code == `FOS_C_CONFIRM) |=>
			cmd_ignored && chip_state == st_pgm_susp;
	endproperty
	a_ignore: assert property (p_ignore)
		else $error("confirm after erase setup in program suspend not dropped");

	property p_clr_busy;
		@(posedge mclk) disable iff (!resetn)
		clr_req && is_busy(chip_state) && status_word[`FOS_SB_VPP] |=>
			status_word[`FOS_SB_VPP];
	endproperty
	a_clr_busy: assert property (p_clr_busy)
		else $error("error bit cleared while sequencer busy");

	property p_bulk_gate;
		@(posedge mclk) disable iff (!resetn)
		chip_state == st_bulk_busy && wr_valid && same_blk && !seq_done |=>
			bulk_data_accept == !$past(bulk_not_ready);
	endproperty
	a_bulk_gate: assert property (p_bulk_gate)
		else $error("bulk data gate wrong");

	property p_lock_ready;
		@(posedge mclk) disable iff (!resetn)
		chip_state == st_lock_setup && wr_valid && code == `FOS_C_LOCK && !esusp |=>
			op_start && op_kind == op_lock && chip_state == st_ready;
	endproperty
	a_lock_ready: assert property (p_lock_ready)
		else $error("lock confirm did not run and return to ready");

	property p_latch;
		@(posedge mclk) disable iff (!resetn)
		(chip_state == st_ready && wr_valid && code == `FOS_C_ERASE) ##1 !wr_valid ##1
			(wr_valid && code == `FOS_C_CONFIRM) |=> op_block == $past(wr_block, 3);
	endproperty
	a_latch: assert property (p_latch)
		else $error("operation block is not the first-cycle address");

	property p_reset;
		@(posedge mclk)
		!resetn |=> part_sel == '0 && chip_state == st_ready;
	endproperty
	a_reset: assert property (p_reset)
		else $error("reset did not restore array selection and ready");

	property p_ready_bit;
		@(posedge mclk) disable iff (!resetn)
		op_start && !(op_kind inside {op_lock, op_unlock, op_lockdown, op_cfg}) |->
			!status_word[`FOS_SB_READY];
	endproperty
	a_ready_bit: assert property (p_ready_bit)
		else $error("ready bit set while busy");

endmodule

// ### dv/fos_seq_model.sv
/*
 * Write sequencer model: counts lat cycles after each start, then pulses
 * completion, optionally with a voltage or locked-block error.
 * Assumes op_start is a one-cycle pulse and pause marks a suspend.
 */
`timescale 1ns/1ps
module fos_seq_model (
	input  logic       mclk,
	input  logic       resetn,
	input  logic       op_start,
	input  logic       pause,
	input  logic [7:0] lat,
	input  logic       vpp_fail,
	input  logic       lock_fail,
	output logic       seq_done,
	output logic       seq_vpp_err,
	output logic       seq_lock_err
);
	logic [7:0] cnt;

	// ****************************************
	// countdown
	// ****************************************
	// lat of zero stalls forever, so bulk runs never finish on their own
	always_ff @(posedge mclk) begin
		seq_done <= 1'b0;
		seq_vpp_err <= 1'b0;
		seq_lock_err <= 1'b0;
		if (!resetn) begin
			cnt <= 8'h00;
		end else if (op_start) begin
			cnt <= lat;
		end else if (cnt != 8'h00 && !pause) begin
			cnt <= cnt - 8'h01;
			seq_done <= (cnt == 8'h01);
			seq_vpp_err <= (cnt == 8'h01) && vpp_fail;
			seq_lock_err <= (cnt == 8'h01) && lock_fail;
		end
	end
endmodule

// ### dv/test_flash_output_select_control.sv
/*
 * Self-checking bench for the output-select control block.
 * Assumes the sequencer model answers op_start after lat cycles.
 */
`timescale 1ns/1ps
module test_flash_output_select_control;
	import fos_pkg::*;
	logic        mclk = 0, resetn = 0, wr_valid = 0, bulk_not_ready = 0, vpp_fail = 0;
	logic [15:0] wr_data = 0, part_sel;
	logic [2:0]  wr_partition = 0, rd_partition = 0, op_partition;
	logic [9:0]  wr_block = 0, op_block;
	logic [7:0]  rd_offset = 0, lat = 8'h05, status_word;
	fos_state_t  chip_state;
	fos_sel_t    rd_sel;
	fos_op_t     op_kind;
	logic        rd_invalid, rd_query, op_start, bulk_data_accept, cmd_ignored, cmd_illegal;
	logic        seq_done, seq_vpp_err, seq_lock_err;
	int          failures = 0, samples_checked = 0, cycles = 0;

	fos_output_select i_dut (.mclk(mclk), .resetn(resetn), .wr_valid(wr_valid),
		.wr_data(wr_data), .wr_partition(wr_partition), .wr_block(wr_block),
		.rd_partition(rd_partition), .rd_offset(rd_offset), .seq_done(seq_done),
		.seq_vpp_err(seq_vpp_err), .seq_lock_err(seq_lock_err),
		.bulk_not_ready(bulk_not_ready), .chip_state(chip_state), .rd_sel(rd_sel),
		.rd_invalid(rd_invalid), .rd_query(rd_query), .part_sel(part_sel),
		.status_word(status_word), .op_start(op_start), .op_kind(op_kind),
		.op_block(op_block), .op_partition(op_partition),
		.bulk_data_accept(bulk_data_accept), .cmd_ignored(cmd_ignored),
		.cmd_illegal(cmd_illegal));
	fos_seq_model i_seq (.mclk(mclk), .resetn(resetn), .op_start(op_start),
		.pause(chip_state == st_pgm_susp), .lat(lat), .vpp_fail(vpp_fail), .lock_fail(vpp_fail),
		.seq_done(seq_done), .seq_vpp_err(seq_vpp_err), .seq_lock_err(seq_lock_err));

	// ****************************************
	// clock, timeout and helpers
	// ****************************************
	always #2 mclk = ~mclk;
	// whole run is well under a thousand cycles
	always @(posedge mclk) begin
		cycles++;
		if (cycles == 5000) begin
			failures++;
			test_done();
		end
	end

	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		samples_checked++;
		if (got !== exp) begin
			failures++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask

	// one write pulse; returns just after the edge that answers it
	task automatic wr(input logic [15:0] d, input logic [2:0] p, input logic [9:0] b);
		@(posedge mclk);
		wr_valid <= 1'b1;
		wr_data <= d;
		wr_partition <= p;
		wr_block <= b;
		@(posedge mclk);
		wr_valid <= 1'b0;
		#1;
	endtask

	function automatic logic [1:0] ps(input int p);
		return part_sel[2*p +: 2];
	endfunction

	task automatic wait_ready;
		for (int n = 0; n < 200 && chip_state !== st_ready; n++) @(posedge mclk);
		#1;
	endtask

	task automatic test_done;
		$display("checks %0d mismatches %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask

	// ****************************************
	// scenarios
	// ****************************************
	task automatic t_reset;
		chk("state", st_ready, chip_state);
		chk("part_sel", 16'h0000, part_sel);
		chk("status", 8'h80, status_word);
	endtask

	// erase with both error kinds, array read of the busy partition
	task automatic t_erase;
		@(posedge mclk);
		rd_partition <= 3'd2;
		vpp_fail <= 1'b1;
		wr(16'h0020, 3'd2, 10'h155);
		chk("sel2", sel_status, ps(2));
		chk("block", 10'h155, op_block);
		chk("opart", 3'd2, op_partition);
		wr(16'h00d0, 3'd2, 10'h2aa);
		chk("block", 10'h155, op_block);
		chk("kind", op_erase, op_kind);
		chk("busy", 1'b0, status_word[7]);
		wr(16'h00ff, 3'd2, 10'h155);
		chk("sel2", sel_array, ps(2));
		chk("invalid", 1'b1, rd_invalid);
		wait_ready();
		chk("sel2", sel_array, ps(2));
		chk("vpp", 1'b1, status_word[3]);
		chk("lockerr", 1'b1, status_word[1]);
		@(posedge mclk);
		vpp_fail <= 1'b0;
	endtask

	// clear-status refused while busy, taken when idle
	task automatic t_clear;
		wr(16'h0040, 3'd4, 10'h000);
		wr(16'h1234, 3'd4, 10'h000);
		chk("state", st_pgm_busy, chip_state);
		wr(16'h0050, 3'd4, 10'h000);
		chk("vpp", 1'b1, status_word[3]);
		chk("lockerr", 1'b1, status_word[1]);
		chk("sel4", sel_status, ps(4));
		wait_ready();
		wr(16'h0050, 3'd4, 10'h000);
		chk("vpp", 1'b0, status_word[3]);
		chk("lockerr", 1'b0, status_word[1]);
	endtask

	task automatic t_codes;
		wr(16'h0090, 3'd0, 10'h000);
		chk("sel0", sel_id, ps(0));
		wr(16'h0098, 3'd1, 10'h000);
		chk("sel1", sel_id, ps(1));
		@(posedge mclk);
		rd_partition <= 3'd1;
		rd_offset <= 8'h10;
		#1;
		chk("rd_sel", sel_id, rd_sel);
		chk("query", 1'b1, rd_query);
		@(posedge mclk);
		rd_offset <= 8'h0f;
		#1;
		chk("ident", 1'b0, rd_query);
		wr(16'h0077, 3'd1, 10'h000);
		chk("illegal", 1'b1, cmd_illegal);
		chk("sel1", sel_id, ps(1));
		wr(16'h0050, 3'd1, 10'h000);
		chk("sel1", sel_id, ps(1));
		wr(16'hffff, 3'd1, 10'h000);
		chk("sel1", sel_array, ps(1));
		chk("sel0", sel_id, ps(0));
		wr(16'h00c0, 3'd5, 10'h000);
		chk("sel5", sel_status, ps(5));
		wr(16'h4321, 3'd5, 10'h000);
		chk("kind", op_otp, op_kind);
		wait_ready();
	endtask

	// lock, unlock, lock-down and configuration confirms
	task automatic t_lock;
		logic [15:0] code [4] = '{16'h0001, 16'h00d0, 16'h002f, 16'h0003};
		fos_op_t     kind [4] = '{op_lock, op_unlock, op_lockdown, op_cfg};
		fos_sel_t    sel [4] = '{sel_status, sel_status, sel_status, sel_array};
		for (int i = 0; i < 4; i++) begin
			wr(16'h0060, 3'd3, 10'h007);
			chk("sel3", sel_status, ps(3));
			wr(code[i], 3'd3, 10'h007);
			chk("start", 1'b1, op_start);
			chk("kind", kind[i], op_kind);
			chk("state", st_ready, chip_state);
			chk("sel3", sel[i], ps(3));
			repeat (8) @(posedge mclk);
		end
	endtask

	task automatic t_suspend;
		lat <= 8'h3c;
		wr(16'h0040, 3'd6, 10'h000);
		wr(16'h5678, 3'd6, 10'h000);
		wr(16'h00b0, 3'd6, 10'h000);
		chk("state", st_pgm_susp, chip_state);
		wr(16'h0020, 3'd6, 10'h000);
		wr(16'h00d0, 3'd6, 10'h000);
		chk("ignored", 1'b1, cmd_ignored);
		chk("state", st_pgm_susp, chip_state);
		wr(16'h00d0, 3'd6, 10'h000);
		chk("state", st_pgm_busy, chip_state);
		wait_ready();
	endtask

	// bulk programming with the far side stalled
	task automatic t_bulk;
		@(posedge mclk);
		lat <= 8'h00;
		wr(16'h0030, 3'd7, 10'h020);
		wr(16'h00d0, 3'd7, 10'h020);
		chk("kind", op_bulk, op_kind);
		@(posedge mclk);
		bulk_not_ready <= 1'b1;
		wr(16'h1111, 3'd7, 10'h020);
		chk("ignored", 1'b1, cmd_ignored);
		chk("bit0", 1'b1, status_word[0]);
		@(posedge mclk);
		bulk_not_ready <= 1'b0;
		wr(16'h2222, 3'd7, 10'h020);
		chk("accept", 1'b1, bulk_data_accept);
		wr(16'hffff, 3'd7, 10'h021);
		chk("state", st_ready, chip_state);
	endtask

	// reset spans five rising edges; release lands on the fifth by NBA
	initial begin
		repeat (4) @(posedge mclk);
		#1;
		t_reset();
		@(posedge mclk);
		resetn <= 1'b1;
		t_erase();
		t_clear();
		t_codes();
		t_lock();
		t_suspend();
		t_bulk();
		test_done();
	end
endmodule
